// [core/sep_array.sv]
module sep_array
	import sep_pkg::*;
#(
	parameter int unsigned WIDTH = WORD_BITS,
	parameter int unsigned AW    = ADDR_BITS,
	parameter int unsigned DEPTH = WORD_COUNT
) (
	// Clock
	input  wire logic             i_clk,
	// Write side
	input  wire logic             i_wr_en,
	input  wire logic             i_wr_all,
	input  wire logic [AW-1:0]    i_wr_addr,
	input  wire logic [WIDTH-1:0] i_wr_data,
	// Read side
	input  wire logic [AW-1:0]    i_rd_addr,
	output logic      [WIDTH-1:0] o_rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	// One word, or every word at once for whole-array programming
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (i_wr_en && (i_wr_all || i_wr_addr == AW'(i))) begin
				mem[i] <= i_wr_data;
			end
		end
	end

	// Registered read port
	always_ff @(posedge i_clk) begin
		o_rd_data <= mem[i_rd_addr];
	end

endmodule : sep_array

// [core/sep_core.sv]
module sep_core
	import sep_pkg::*;
(
	// Clock and reset
	input  wire logic I_CLOCK,
	input  wire logic I_RESET,
	// Serial port from the controller
	input  wire logic I_CHIP_SELECT,
	input  wire logic I_SERIAL_CLOCK,
	input  wire logic I_SERIAL_IN,
	// Serial data out, three-state
	output logic      O_SERIAL_OUT,
	output logic      O_SERIAL_OUT_OE,
	// Status
	output logic      O_PROG_VOLTAGE,
	output logic      O_PROG_ENABLE,
	output logic      O_STANDBY
);

	sep_state_e            state_ff;
	sep_state_e            nxt_state;
	logic                  sclk_d_ff;
	logic                  cs_d_ff;
	logic [CMD_BITS-1:0]   cmd_ff;
	logic [CMD_BITS-1:0]   nxt_cmd;
	logic [WORD_BITS-1:0]  data_ff;
	logic [WORD_BITS-1:0]  nxt_data;
	logic [WORD_BITS-1:0]  shift_ff;
	logic [WORD_BITS-1:0]  nxt_shift;
	logic [CNT_BITS-1:0]   cnt_ff;
	logic [CNT_BITS-1:0]   nxt_cnt;
	logic                  loaded_ff;
	logic                  nxt_loaded;
	logic                  so_ff;
	logic                  nxt_so;
	logic                  oe_ff;
	logic                  nxt_oe;
	logic                  en_ff;
	logic                  nxt_en;
	logic                  pv_ff;
	logic                  stby_ff;
	logic                  wr_en;
	logic [WORD_BITS-1:0]  rd_data;

	// Edge detection on the sampled serial inputs
	wire sclk_rise = I_SERIAL_CLOCK & ~sclk_d_ff;
	wire cs_fall   = ~I_CHIP_SELECT & cs_d_ff;
	wire sample    = sclk_rise & I_CHIP_SELECT;

	// Opcode and address decode of the held instruction
	wire [3:0]           op      = cmd_ff[OP_MSB:OP_LSB];
	wire [ADDR_BITS-1:0] addr    = cmd_ff[ADDR_MSB:0];
	wire                 is_er   = op[3:2] == OPH_ERASE;
	wire                 is_erase_all_cmd = op == OP_ERASE_ALL;
	wire                 is_write_all_cmd = op == OP_WRITE_ALL;
	wire                 is_all  = is_erase_all_cmd | is_write_all_cmd;
	wire                 is_ers  = is_er | is_erase_all_cmd;

	// Next instruction value, shifted in MSB first
	wire [CMD_BITS-1:0] cmd_shift = {cmd_ff[CMD_BITS-2:0], I_SERIAL_IN};
	wire [3:0]          new_op    = cmd_shift[OP_MSB:OP_LSB];
	wire                new_read  = new_op[3:2] == OPH_READ;
	wire                new_wdata = new_op[3:2] == OPH_WRITE
	                                | new_op == OP_WRITE_ALL;
	wire                new_ers   = new_op[3:2] == OPH_ERASE
	                                | new_op == OP_ERASE_ALL;

	// Array write data: ones for erase, shifted data otherwise
	wire [WORD_BITS-1:0] wr_data = is_ers ? ERASED_WORD : data_ff;
	assign wr_en = (state_ff == ST_ARMED) && cs_fall;

	sep_array u_array (
		.i_clk     (I_CLOCK),
		.i_wr_en   (wr_en),
		.i_wr_all  (is_all),
		.i_wr_addr (addr),
		.i_wr_data (wr_data),
		.i_rd_addr (addr),
		.o_rd_data (rd_data)
	);

	// Sequencer next state and datapath
	always_comb begin
		nxt_state  = state_ff;
		nxt_cmd    = cmd_ff;
		nxt_data   = data_ff;
		nxt_shift  = shift_ff;
		nxt_cnt    = cnt_ff;
		nxt_loaded = loaded_ff;
		nxt_so     = so_ff;
		nxt_oe     = oe_ff;
		nxt_en     = en_ff;
		unique case (state_ff)
			ST_IDLE: begin
				nxt_oe = 1'b0;
				// Leading zeros are skipped until the start bit
				if (sample && I_SERIAL_IN) begin
					nxt_state = ST_CMD;
					nxt_cnt   = '0;
				end
			end
			ST_CMD: begin
				if (!I_CHIP_SELECT) begin
					nxt_state = ST_IDLE;
				end else if (sample) begin
					nxt_cmd = cmd_shift;
					nxt_cnt = cnt_ff + CNT_BITS'(1);
					if (cnt_ff == CMD_LAST) begin
						nxt_cnt = '0;
						if (new_read) begin
							// Dummy zero driven on this rise
							nxt_state  = ST_READ;
							nxt_so     = 1'b0;
							nxt_oe     = 1'b1;
							nxt_loaded = 1'b0;
						end else if (new_wdata) begin
							nxt_state = ST_DATA;
						end else if (new_ers && en_ff) begin
							nxt_state = ST_ARMED;
						end else begin
							nxt_state = ST_DONE;
							if (new_op == OP_PROG_ENABLE) begin
								nxt_en = 1'b1;
							end
							if (new_op == OP_PROG_DISABLE) begin
								nxt_en = 1'b0;
							end
						end
					end
				end
			end
			ST_DATA: begin
				if (!I_CHIP_SELECT) begin
					nxt_state = ST_IDLE;
				end else if (sample) begin
					nxt_data = {data_ff[WORD_BITS-2:0], I_SERIAL_IN};
					nxt_cnt  = cnt_ff + CNT_BITS'(1);
					if (cnt_ff == WORD_LAST) begin
						nxt_state = en_ff ? ST_ARMED : ST_DONE;
					end
				end
			end
			ST_READ: begin
				if (!I_CHIP_SELECT) begin
					nxt_state = ST_IDLE;
					nxt_oe    = 1'b0;
				end else if (sample) begin
					nxt_cnt = cnt_ff + CNT_BITS'(1);
					if (!loaded_ff) begin
						// Word enters the output shifter
						nxt_so     = rd_data[WORD_BITS-1];
						nxt_shift  = {rd_data[WORD_BITS-2:0], 1'b0};
						nxt_loaded = 1'b1;
					end else if (cnt_ff == WORD_LAST + CNT_BITS'(1)) begin
						nxt_state = ST_DONE;
						nxt_oe    = 1'b0;
					end else begin
						nxt_so    = shift_ff[WORD_BITS-1];
						nxt_shift = {shift_ff[WORD_BITS-2:0], 1'b0};
					end
				end
			end
			ST_DONE: begin
				nxt_oe = 1'b0;
				if (!I_CHIP_SELECT) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_ARMED: begin
				// Extra clocks are ignored until select falls
				if (cs_fall) begin
					nxt_state = ST_PROG;
				end
			end
			ST_PROG: begin
				// No serial clock needed while programming
				if (I_CHIP_SELECT) begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	// Sampled pins and edge history
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			sclk_d_ff <= 1'b0;
			cs_d_ff   <= 1'b0;
		end else begin
			sclk_d_ff <= I_SERIAL_CLOCK;
			cs_d_ff   <= I_CHIP_SELECT;
		end
	end

	// Sequencer and shift registers
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			state_ff  <= ST_IDLE;
			cmd_ff    <= '0;
			data_ff   <= '0;
			shift_ff  <= '0;
			cnt_ff    <= '0;
			loaded_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			cmd_ff    <= nxt_cmd;
			data_ff   <= nxt_data;
			shift_ff  <= nxt_shift;
			cnt_ff    <= nxt_cnt;
			loaded_ff <= nxt_loaded;
		end
	end

	// Output pin, enable latch and status flops
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			so_ff <= 1'b0;
			oe_ff <= 1'b0;
			en_ff <= PROG_ENABLE_RST;
			pv_ff <= 1'b0;
			stby_ff <= 1'b0;
		end else begin
			so_ff <= nxt_so;
			oe_ff <= nxt_oe;
			en_ff <= nxt_en;
			pv_ff <= nxt_state == ST_PROG;
			stby_ff <= !I_CHIP_SELECT && nxt_state != ST_PROG;
		end
	end

	// Ports straight from flops
	assign O_SERIAL_OUT    = so_ff;
	assign O_SERIAL_OUT_OE = oe_ff;
	assign O_PROG_VOLTAGE  = pv_ff;
	assign O_PROG_ENABLE   = en_ff;
	assign O_STANDBY       = stby_ff;

endmodule : sep_core

// [core/sep_pkg.sv]
package sep_pkg;

	// Word organisation of the array
	localparam int unsigned WORD_BITS = 16;
	localparam int unsigned ADDR_BITS = 4;
	localparam int unsigned WORD_COUNT = 16;

	// Instruction layout after the start bit: opcode then address
	localparam int unsigned CMD_BITS = 8;
	localparam int unsigned OP_MSB = 7;
	localparam int unsigned OP_LSB = 4;
	localparam int unsigned ADDR_MSB = 3;
	localparam int unsigned CNT_BITS = 5;
	localparam logic [4:0] CMD_LAST = 5'h07;
	localparam logic [4:0] WORD_LAST = 5'h0F;

	// Single-word opcodes, decoded on the two upper bits
	localparam logic [1:0] OPH_READ = 2'h2;
	localparam logic [1:0] OPH_WRITE = 2'h1;
	localparam logic [1:0] OPH_ERASE = 2'h3;

	// Whole-array and enable opcodes, full four bits
	localparam logic [3:0] OP_PROG_ENABLE = 4'h3;
	localparam logic [3:0] OP_PROG_DISABLE = 4'h0;
	localparam logic [3:0] OP_ERASE_ALL = 4'h2;
	localparam logic [3:0] OP_WRITE_ALL = 4'h1;

	// Value of an erased word and reset values
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic PROG_ENABLE_RST = 1'b0;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_DATA,
		ST_READ,
		ST_DONE,
		ST_ARMED,
		ST_PROG
	} sep_state_e;

endpackage : sep_pkg

// [verif/sep_core_checker.sv]
module sep_core_checker
	import sep_pkg::*;
(
	// Clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	// Serial port
	input wire logic I_CHIP_SELECT,
	input wire logic I_SERIAL_CLOCK,
	input wire logic I_SERIAL_IN,
	// Design outputs
	input wire logic O_SERIAL_OUT,
	input wire logic O_SERIAL_OUT_OE,
	input wire logic O_PROG_VOLTAGE,
	input wire logic O_PROG_ENABLE,
	input wire logic O_STANDBY
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sclk_ff;
	logic rise_q;
	logic rise;

	// Serial clock rise seen with select high
	assign rise = I_SERIAL_CLOCK & ~sclk_ff & I_CHIP_SELECT;
	always_ff @(posedge I_CLOCK) begin
		sclk_ff <= I_SERIAL_CLOCK;
		rise_q  <= rise;
	end

	default clocking @(posedge I_CLOCK);
	endclocking
	default disable iff (I_RESET);

	// Select low with no programming under way
	sequence quiet;
		!I_CHIP_SELECT && !O_PROG_VOLTAGE;
	endsequence

	chk_drive_needs_select: assert property (
		!I_CHIP_SELECT |=> !O_SERIAL_OUT_OE) else $error("out driven");
	chk_dummy_bit_first: assert property (
		$rose(O_SERIAL_OUT_OE) |-> rise_q && !O_SERIAL_OUT)
		else $error("bad dummy bit");
	chk_out_on_rise: assert property (
		O_SERIAL_OUT_OE && $changed(O_SERIAL_OUT) |-> rise_q)
		else $error("out moved off rise");
	chk_prog_at_fall: assert property (
		$rose(O_PROG_VOLTAGE) |->
		$past(I_CHIP_SELECT, 2) && !$past(I_CHIP_SELECT))
		else $error("prog start");
	chk_prog_select_ends: assert property (
		O_PROG_VOLTAGE && I_CHIP_SELECT |=> !O_PROG_VOLTAGE)
		else $error("prog end");
	chk_prog_select_low: assert property (
		O_PROG_VOLTAGE |-> !$past(I_CHIP_SELECT)) else $error("prog mode");
	chk_prog_needs_enable: assert property (
		$rose(O_PROG_VOLTAGE) |-> O_PROG_ENABLE) else $error("prog gated");
	chk_standby_on: assert property (
		quiet ##1 quiet |-> O_STANDBY) else $error("no standby");
	chk_standby_off: assert property (
		O_STANDBY |-> !$past(I_CHIP_SELECT)) else $error("bad standby");
	chk_enable_on_bit: assert property (
		$changed(O_PROG_ENABLE) |-> rise_q) else $error("latch moved");
endmodule : sep_core_checker

bind sep_core sep_core_checker u_chk (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
	.I_CHIP_SELECT(I_CHIP_SELECT), .I_SERIAL_CLOCK(I_SERIAL_CLOCK),
	.I_SERIAL_IN(I_SERIAL_IN), .O_SERIAL_OUT(O_SERIAL_OUT),
	.O_SERIAL_OUT_OE(O_SERIAL_OUT_OE), .O_PROG_VOLTAGE(O_PROG_VOLTAGE),
	.O_PROG_ENABLE(O_PROG_ENABLE), .O_STANDBY(O_STANDBY));

// [verif/sep_ctrl_model.sv]
module sep_ctrl_model (
	// Clock and returned data
	input  wire logic i_clk,
	input  wire logic i_out,
	input  wire logic i_out_oe,
	// Serial lines to the device
	output logic      o_cs,
	output logic      o_sclk,
	output logic      o_sdat
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_ff = 1'b0;
	logic line;

	// Released data line shows the inverse of its last value
	always_ff @(posedge i_clk) if (i_out_oe) last_ff <= i_out;
	assign line = i_out_oe ? i_out : ~last_ff;
	initial begin
		o_cs = 1'b0;
		o_sclk = 1'b0;
		o_sdat = 1'b0;
	end

	// One bit: data set with clock low, reply taken after the rise
	task automatic shift(input logic b, output logic r);
		@(negedge i_clk);
		o_sclk = 1'b0;
		o_sdat = b;
		repeat (2) @(negedge i_clk);
		o_sclk = 1'b1;
		repeat (2) @(negedge i_clk);
		r = line;
	endtask : shift

	// Lead clock, instruction, then optional word, MSB first
	task automatic frame(input logic [8:0] ins, input logic [15:0] d,
		input int nd, output logic [15:0] q, output logic dmy);
		logic r;
		o_cs = 1'b1;
		shift(1'b0, r);
		for (int i = 8; i >= 0; i--) shift(ins[i], r);
		dmy = r;
		for (int i = nd - 1; i >= 0; i--) begin
			shift(d[i], r);
			q[i] = r;
		end
		@(negedge i_clk);
		o_sclk = 1'b0; // Clock stands still outside bits
	endtask : frame

	// Select low for a gap or programming time
	task automatic stop(input int n);
		@(negedge i_clk);
		o_cs = 1'b0;
		repeat (n) @(negedge i_clk);
	endtask : stop

	// Select high after programming
	task automatic high(input int n);
		@(negedge i_clk);
		o_cs = 1'b1;
		repeat (n) @(negedge i_clk);
	endtask : high
endmodule : sep_ctrl_model

// [verif/tb_serial_eeprom_command_port.sv]
module tb_serial_eeprom_command_port;
	import sep_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, a) begin \
	compares++; \
	if ((a) !== (e)) begin \
		failures++; \
		$display("BAD %s exp %h got %h", n, e, a); \
	end \
end
	logic        I_CLOCK = 1'b0;
	logic        I_RESET = 1'b1;
	int          failures = 0;
	int          compares = 0;
	int          cycles = 0;
	logic        cs, sclk, sdat, so, oe, pv, pe, stby, dm;
	logic [15:0] q;

	always #2 I_CLOCK = ~I_CLOCK;
	sep_ctrl_model ctl (.i_clk(I_CLOCK), .i_out(so), .i_out_oe(oe),
		.o_cs(cs), .o_sclk(sclk), .o_sdat(sdat));
	sep_core dut (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_CHIP_SELECT(cs),
		.I_SERIAL_CLOCK(sclk), .I_SERIAL_IN(sdat), .O_SERIAL_OUT(so),
		.O_SERIAL_OUT_OE(oe), .O_PROG_VOLTAGE(pv), .O_PROG_ENABLE(pe),
		.O_STANDBY(stby));

	// Verdict and end of run
	task automatic final_report();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	// Hang guard
	always @(posedge I_CLOCK) begin
		cycles++;
		if (cycles == 12000) begin
			failures++;
			final_report();
		end
	end

	// Enable or disable command, latch seen right after
	task automatic cmd(input logic [3:0] op, input logic exp);
		ctl.frame({1'b1, op, 4'h9}, 16'h0000, 0, q, dm);
		`CHK("enable_latch", exp, pe)
		ctl.stop(2);
	endtask : cmd

	// Programming instruction, then select low and high again
	task automatic prog(input logic [3:0] op, input logic [3:0] a,
		input logic [15:0] d, input int nd, input logic exp);
		ctl.frame({1'b1, op, a}, d, nd, q, dm);
		ctl.stop(3); // Shortened programming time
		`CHK("prog_voltage", exp, pv)
		ctl.high(2);
		`CHK("prog_end", 1'b0, pv)
		ctl.stop(2);
		`CHK("standby", 1'b1, stby)
	endtask : prog

	// Read a word: dummy zero then sixteen bits
	task automatic rd(input logic [3:0] op, input logic [3:0] a,
		input logic [15:0] exp);
		ctl.frame({1'b1, op, a}, 16'h0000, 16, q, dm);
		`CHK("dummy", 1'b0, dm)
		`CHK("read_word", exp, q)
		`CHK("drive_on", 1'b1, oe)
		ctl.stop(2);
		`CHK("drive_off", 1'b0, oe)
	endtask : rd

	// Latch set, cleared, set again
	task automatic t_latch();
		cmd(4'h3, 1'b1);
		cmd(4'h0, 1'b0);
		cmd(4'h3, 1'b1);
	endtask : t_latch

	// Whole-array erase, single write and erase, whole-array write
	task automatic t_program();
		prog(4'h2, 4'h7, 16'h0000, 0, 1'b1);
		rd(4'h8, 4'h3, 16'hFFFF);
		prog(4'h6, 4'h5, 16'hA5C3, 16, 1'b1);
		rd(4'hB, 4'h5, 16'hA5C3);
		rd(4'h8, 4'h4, 16'hFFFF);
		prog(4'hD, 4'h5, 16'h0000, 0, 1'b1);
		rd(4'h9, 4'h5, 16'hFFFF);
		prog(4'h1, 4'h0, 16'h1234, 16, 1'b1);
		rd(4'h8, 4'h0, 16'h1234);
		rd(4'h8, 4'hF, 16'h1234);
	endtask : t_program

	// Latch clear: programming refused, reads still work
	task automatic t_refused();
		cmd(4'h0, 1'b0);
		prog(4'h2, 4'h0, 16'h0000, 0, 1'b0);
		prog(4'h4, 4'h6, 16'h0000, 16, 1'b0);
		prog(4'hC, 4'h6, 16'h0000, 0, 1'b0);
		rd(4'h8, 4'h6, 16'h1234);
	endtask : t_refused

	initial begin
		repeat (4) @(negedge I_CLOCK);
		I_RESET = 1'b0;
		repeat (2) @(negedge I_CLOCK);
		`CHK("reset_oe", 1'b0, oe)
		`CHK("reset_latch", PROG_ENABLE_RST, pe)
		t_latch();
		t_program();
		t_refused();
		final_report();
	end
endmodule : tb_serial_eeprom_command_port
